// ===== design/ddr2p_defs.vh
// Constants for the DDR2 memory pin interface
`ifndef DDR2P_DEFS_VH
`define DDR2P_DEFS_VH

// Command codes on {row, column, write} strobes, active low
`define DDR2P_CMD_NOP       3'h7
`define DDR2P_CMD_LOAD_MODE 3'h0
// Pin values while reset is asserted
`define DDR2P_ADDR_RST      16'h0000
`define DDR2P_BANK_RST      3'h0
`define DDR2P_CMD_RST       3'h7
`define DDR2P_CKE_RST       1'b0
`define DDR2P_CS_RST        4'hf
`define DDR2P_DM_RST        2'h3
`define DDR2P_CLK_RST       1'b0
`define DDR2P_ODT_RST       1'b0
// Synchroniser depth for pins from outside the clock domain
`define DDR2P_SYNC_STAGES   2

`endif

// ===== design/ddr2p_sync.v
// Two-stage synchroniser for inputs from outside the clock domain
`timescale 1ns/1ns
module ddr2p_sync #(
    parameter WIDTH = 1
) (
    input  wire             clk_i,
    input  wire             rstn_i,
    input  wire [WIDTH-1:0] d_i,
    output wire [WIDTH-1:0] q_o
);
    reg [WIDTH-1:0] meta_q;
    reg [WIDTH-1:0] sync_q;

    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            meta_q <= {WIDTH{1'b0}};
            sync_q <= {WIDTH{1'b0}};
        end
        else
        begin
            meta_q <= d_i;
            sync_q <= meta_q;
        end
    end

    assign q_o = sync_q;
endmodule // ddr2p_sync

// ===== design/ddr2p_pins.v
// DDR2 memory pin interface: command, address, data, strobe and clock pins
`timescale 1ns/1ns
`include "ddr2p_defs.vh"
module ddr2p_pins #(
    parameter AW = 16,
    parameter DW = 16
) (
    input  wire          clk_i,
    input  wire          rstn_i,
    // User command side
    input  wire          cmd_valid_i,
    input  wire [2:0]    cmd_code_i,
    input  wire [2:0]    cmd_bank_i,
    input  wire [AW-1:0] cmd_addr_i,
    input  wire [1:0]    cmd_ext_bank_i,
    input  wire          cke_i,
    input  wire          odt_i,
    input  wire          strobe_diff_i,
    input  wire          clk_a_en_i,
    input  wire          clk_b_en_i,
    // User write side
    input  wire          wr_valid_i,
    input  wire [DW-1:0] wr_data_i,
    input  wire [1:0]    wr_mask_i,
    // User read side
    input  wire          rd_window_i,
    output reg  [DW-1:0] rd_data_o,
    output reg           rd_valid_o,
    // Memory pins
    output reg  [AW-1:0] mem_row_col_addr_out_o,
    output reg  [2:0]    mem_bank_select_out_o,
    output reg           row_strobe_out_o,
    output reg           column_strobe_out_o,
    output reg           write_enable_out_o,
    output reg           mem_clock_enable_out_o,
    output reg  [3:0]    mem_chip_select_n_o,
    output reg           termination_enable_out_o,
    output reg           ctrl_oe_o,
    output reg  [1:0]    write_byte_mask_o,
    output reg  [DW-1:0] mem_data_bus_o,
    output reg           mem_data_bus_oe_o,
    input  wire [DW-1:0] mem_data_bus_i,
    output reg  [1:0]    byte_lane_strobe_p_o,
    output reg  [1:0]    byte_lane_strobe_n_o,
    output reg           byte_lane_strobe_p_oe_o,
    output reg           byte_lane_strobe_n_oe_o,
    input  wire [1:0]    byte_lane_strobe_p_i,
    output reg           mem_clock_pair_a_p_o,
    output reg           mem_clock_pair_a_n_o,
    output reg           mem_clock_pair_b_p_o,
    output reg           mem_clock_pair_b_n_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin enable: all control pins float in reset, driven from first edge on
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
            ctrl_oe_o <= 1'b0;
        else
            ctrl_oe_o <= 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Command, bank and address pins, one cycle per command then idle
    reg [3:0] cs_dec_n;
    integer   i;

    always @*
    begin
        cs_dec_n = 4'hf;
        for (i = 0; i < 4; i = i + 1)
        begin
            if (cmd_ext_bank_i == i[1:0])
                cs_dec_n[i] = 1'b0;
        end
    end

    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mem_row_col_addr_out_o <= `DDR2P_ADDR_RST;
            mem_bank_select_out_o  <= `DDR2P_BANK_RST;
            {row_strobe_out_o, column_strobe_out_o, write_enable_out_o} <= `DDR2P_CMD_RST;
            mem_chip_select_n_o    <= `DDR2P_CS_RST;
        end
        else if (cmd_valid_i)
        begin
            mem_row_col_addr_out_o <= cmd_addr_i;
            // Bank or mode-register selector, per command kind
            mem_bank_select_out_o  <= cmd_bank_i;
            {row_strobe_out_o, column_strobe_out_o, write_enable_out_o} <= cmd_code_i;
            mem_chip_select_n_o    <= cs_dec_n;
        end
        else
        begin
            mem_row_col_addr_out_o <= `DDR2P_ADDR_RST;
            mem_bank_select_out_o  <= `DDR2P_BANK_RST;
            {row_strobe_out_o, column_strobe_out_o, write_enable_out_o} <= `DDR2P_CMD_NOP;
            // Deselect all banks so idle cycles carry no command
            mem_chip_select_n_o    <= `DDR2P_CS_RST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clock enable and termination levels
    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mem_clock_enable_out_o   <= `DDR2P_CKE_RST;
            termination_enable_out_o <= `DDR2P_ODT_RST;
        end
        else
        begin
            mem_clock_enable_out_o   <= cke_i;
            termination_enable_out_o <= odt_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Memory clocks: half rate of clk_i, each pair gated by its enable
    reg mclk_q;

    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mclk_q               <= 1'b0;
            mem_clock_pair_a_p_o <= `DDR2P_CLK_RST;
            mem_clock_pair_a_n_o <= `DDR2P_CLK_RST;
            mem_clock_pair_b_p_o <= `DDR2P_CLK_RST;
            mem_clock_pair_b_n_o <= `DDR2P_CLK_RST;
        end
        else
        begin
            mclk_q               <= ~mclk_q;
            mem_clock_pair_a_p_o <= clk_a_en_i & ~mclk_q;
            mem_clock_pair_a_n_o <= clk_a_en_i &  mclk_q;
            mem_clock_pair_b_p_o <= clk_b_en_i & ~mclk_q;
            mem_clock_pair_b_n_o <= clk_b_en_i &  mclk_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write path: each beat drives data, mask and a strobe transition
    reg [1:0] wstrb_q;

    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            mem_data_bus_o          <= {DW{1'b0}};
            mem_data_bus_oe_o       <= 1'b0;
            write_byte_mask_o       <= `DDR2P_DM_RST;
            wstrb_q                 <= 2'h0;
            byte_lane_strobe_p_o    <= 2'h0;
            byte_lane_strobe_n_o    <= 2'h3;
            byte_lane_strobe_p_oe_o <= 1'b0;
            byte_lane_strobe_n_oe_o <= 1'b0;
        end
        else
        begin
            mem_data_bus_oe_o       <= wr_valid_i;
            byte_lane_strobe_p_oe_o <= wr_valid_i;
            byte_lane_strobe_n_oe_o <= wr_valid_i & strobe_diff_i;
            if (wr_valid_i)
            begin
                mem_data_bus_o       <= wr_data_i;
                // Mask bit k covers byte lane k
                write_byte_mask_o    <= wr_mask_i;
                wstrb_q              <= ~wstrb_q;
                byte_lane_strobe_p_o <= ~wstrb_q;
                byte_lane_strobe_n_o <= wstrb_q;
            end
            else
            begin
                write_byte_mask_o    <= `DDR2P_DM_RST;
                wstrb_q              <= 2'h0;
                byte_lane_strobe_p_o <= 2'h0;
                byte_lane_strobe_n_o <= 2'h3;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read path: strobe and data synchronised, captured on each lane 0 strobe edge while rd_window_i is high
    wire [1:0]    rstrb_s;
    wire [DW-1:0] rdata_s;
    reg  [1:0]    rstrb_q;
    wire          rd_edge;

    ddr2p_sync #(
        .WIDTH (2+DW)
    ) u_rd_sync (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .d_i    ({byte_lane_strobe_p_i, mem_data_bus_i}),
        .q_o    ({rstrb_s, rdata_s})
    );

    // Lane 0 strobe times the word; both edges carry data
    assign rd_edge = rd_window_i & (rstrb_s[0] ^ rstrb_q[0]);

    always @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            rstrb_q    <= 2'h0;
            rd_data_o  <= {DW{1'b0}};
            rd_valid_o <= 1'b0;
        end
        else
        begin
            rstrb_q    <= rstrb_s;
            rd_valid_o <= rd_edge;
            if (rd_edge)
                rd_data_o <= rdata_s;
        end
    end
endmodule // ddr2p_pins

// ===== testbench/ddr2p_pins_properties.sv
// Checker watching the DDR2 pin interface ports
`timescale 1ns/1ns
module ddr2p_chk #(parameter AW = 16, parameter DW = 16) (
    input wire clk_i, rstn_i, cmd_valid_i, cke_i, odt_i, strobe_diff_i, clk_a_en_i,
    input wire wr_valid_i, rd_window_i, rd_valid_o, ctrl_oe_o, mem_data_bus_oe_o,
    input wire row_strobe_out_o, column_strobe_out_o, write_enable_out_o,
    input wire mem_clock_enable_out_o, termination_enable_out_o, byte_lane_strobe_n_oe_o,
    input wire mem_clock_pair_a_p_o, mem_clock_pair_a_n_o,
    input wire [2:0] cmd_code_i, cmd_bank_i, mem_bank_select_out_o,
    input wire [1:0] cmd_ext_bank_i, wr_mask_i, write_byte_mask_o, byte_lane_strobe_p_i,
    input wire [1:0] byte_lane_strobe_p_o, byte_lane_strobe_n_o,
    input wire [3:0] mem_chip_select_n_o,
    input wire [AW-1:0] cmd_addr_i, mem_row_col_addr_out_o,
    input wire [DW-1:0] wr_data_i, mem_data_bus_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire [2:0] cmd = {row_strobe_out_o, column_strobe_out_o, write_enable_out_o};
    property p_up; $rose(rstn_i) |=> ctrl_oe_o && !mem_data_bus_oe_o; endproperty
    a_up: assert property (p_up) else $error("pins not driven after reset");
    property p_idle; !$past(cmd_valid_i) |-> mem_row_col_addr_out_o == 0 && cmd == 3'h7
        && mem_chip_select_n_o == 4'hf; endproperty
    a_idle: assert property (p_idle) else $error("idle pins wrong");
    property p_cmd; $past(cmd_valid_i) |-> cmd == $past(cmd_code_i) && mem_row_col_addr_out_o
        == $past(cmd_addr_i) && mem_bank_select_out_o == $past(cmd_bank_i); endproperty
    a_cmd: assert property (p_cmd) else $error("command pins wrong");
    property p_cs; $past(cmd_valid_i) |->
        mem_chip_select_n_o == ~(4'h1 << $past(cmd_ext_bank_i)); endproperty
    a_cs: assert property (p_cs) else $error("chip select decode wrong");
    property p_lvl; $past(rstn_i) |-> mem_clock_enable_out_o == $past(cke_i)
        && termination_enable_out_o == $past(odt_i); endproperty
    a_lvl: assert property (p_lvl) else $error("cke or odt wrong");
    property p_wr; $past(wr_valid_i) |-> mem_data_bus_oe_o && mem_data_bus_o
        == $past(wr_data_i) && write_byte_mask_o == $past(wr_mask_i); endproperty
    a_wr: assert property (p_wr) else $error("write beat wrong");
    property p_wr_end; !$past(wr_valid_i) |-> !mem_data_bus_oe_o
        && write_byte_mask_o == 2'h3; endproperty
    a_wr_end: assert property (p_wr_end) else $error("bus not released");
    property p_diff; $past(wr_valid_i) |-> byte_lane_strobe_n_oe_o == $past(strobe_diff_i)
        && byte_lane_strobe_n_o == ~byte_lane_strobe_p_o; endproperty
    a_diff: assert property (p_diff) else $error("strobe style wrong");
    property p_gate; !clk_a_en_i [*2] |-> !mem_clock_pair_a_p_o && !mem_clock_pair_a_n_o;
    endproperty
    a_gate: assert property (p_gate) else $error("clock not gated");
    property p_rd; rd_window_i && $changed(byte_lane_strobe_p_i[0]) |-> ##[2:4] rd_valid_o;
    endproperty
    a_rd: assert property (p_rd) else $error("read capture missing");
    c_load: cover property (cmd_valid_i && cmd_code_i == 3'h0);
    c_burst: cover property (wr_valid_i [*3]);
    c_read: cover property (rd_valid_o);
endmodule // ddr2p_chk
bind ddr2p_pins ddr2p_chk #(.AW(AW), .DW(DW)) chk_u (.*);

// ===== testbench/ddr2p_mem.sv
// Behavioural memory answering reads on data and strobe pins
`timescale 1ns/1ns
module ddr2p_mem (
    input  wire        rd_i,
    input  wire [15:0] word_i,
    output reg  [15:0] dq_o,
    output reg  [1:0]  dqs_o
);
    // Strobe half period 40 ns, runs only in a burst; data leads it
    initial
    begin
        dq_o = 16'h0000;
        dqs_o = 2'h0;
        forever
        begin
            wait (rd_i);
            while (rd_i)
            begin
                #1 dq_o = word_i;
                #10 dqs_o = ~dqs_o;
                #29;
            end
            // Released data and strobe show the inverse of their last level
            #2 dq_o = ~dq_o;
            dqs_o = ~dqs_o;
        end
    end
endmodule // ddr2p_mem

// ===== testbench/ddr2p_pins_test.sv
// Self-checking bench for the DDR2 pin interface
`timescale 1ns/1ns
module ddr2p_pins_test;
    reg clk_i, rstn_i, cmd_valid_i, cke_i, odt_i, strobe_diff_i, clk_a_en_i, clk_b_en_i;
    reg wr_valid_i, rd_window_i, rd_go;
    reg [2:0] cmd_code_i, cmd_bank_i;
    reg [1:0] cmd_ext_bank_i, wr_mask_i;
    reg [15:0] cmd_addr_i, wr_data_i, word;
    wire [15:0] rd_data_o, addr, dq_o, mem_dq, dq_in;
    wire [2:0] bank;
    wire [3:0] cs_n;
    wire [1:0] dm, sp, sn, mem_dqs, sp_in;
    wire rd_valid_o, ras, cas, we, cke, odt, ctrl_oe, dq_oe, sp_oe, sn_oe, ca_p, ca_n, cb_p, cb_n;
    integer n_errors = 0, checks = 0, i, b;
    reg [15:0] exp_q[$];
    assign dq_in = dq_oe ? dq_o : mem_dq;
    assign sp_in = sp_oe ? sp : mem_dqs;
    ddr2p_pins dut_u (.*, .mem_row_col_addr_out_o(addr), .mem_bank_select_out_o(bank),
        .row_strobe_out_o(ras), .column_strobe_out_o(cas), .write_enable_out_o(we),
        .mem_clock_enable_out_o(cke), .mem_chip_select_n_o(cs_n), .termination_enable_out_o(odt),
        .ctrl_oe_o(ctrl_oe), .write_byte_mask_o(dm), .mem_data_bus_o(dq_o),
        .mem_data_bus_oe_o(dq_oe), .mem_data_bus_i(dq_in), .byte_lane_strobe_p_o(sp),
        .byte_lane_strobe_n_o(sn), .byte_lane_strobe_p_oe_o(sp_oe),
        .byte_lane_strobe_n_oe_o(sn_oe), .byte_lane_strobe_p_i(sp_in),
        .mem_clock_pair_a_p_o(ca_p), .mem_clock_pair_a_n_o(ca_n),
        .mem_clock_pair_b_p_o(cb_p), .mem_clock_pair_b_n_o(cb_n));
    ddr2p_mem mem_u (.rd_i(rd_go), .word_i(word), .dq_o(mem_dq), .dqs_o(mem_dqs));
    task chk(input [47:0] got, input [47:0] exp);
    begin
        checks = checks + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    end
    endtask
    task conclude;
    begin
        if (n_errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    end
    endtask
    initial
    begin
        clk_i = 0;
        forever #5 clk_i = ~clk_i;
    end
    initial
    begin
        #200000 n_errors = n_errors + 1;
        conclude;
    end
    always @(negedge clk_i)
        if (rd_valid_o === 1'b1)
            chk(rd_data_o, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
    initial
    begin
        {rstn_i, cmd_valid_i, cke_i, odt_i, strobe_diff_i, clk_a_en_i, clk_b_en_i} = 0;
        {wr_valid_i, rd_window_i, rd_go, cmd_code_i, cmd_bank_i, cmd_ext_bank_i} = 0;
        {wr_mask_i, cmd_addr_i, wr_data_i, word} = 0;
        b = $urandom(68176);
        repeat (2) @(negedge clk_i);
        chk({ctrl_oe, dq_oe, sp_oe, sn_oe}, 4'h0);
        rstn_i = 1;
        @(negedge clk_i);
        chk({ctrl_oe, dq_oe, sp_oe, cs_n, ras, cas, we, cke, odt, dm, addr, bank, ca_p, cb_p},
            {3'h4, 4'hf, 3'h7, 2'h0, 2'h3, 16'h0, 3'h0, 2'h0});
        for (i = 0; i < 24; i = i + 1)
        begin
            {cke_i, odt_i, cmd_valid_i, cmd_bank_i, cmd_addr_i, cmd_ext_bank_i} = $urandom;
            cmd_code_i = i[2:0];
            @(negedge clk_i);
            if (cmd_valid_i)
                chk({ras, cas, we, bank, addr, cs_n}, {cmd_code_i, cmd_bank_i, cmd_addr_i,
                    ~(4'h1 << cmd_ext_bank_i)});
            else
                chk({ras, cas, we, bank, addr, cs_n}, {6'h38, 16'h0, 4'hf});
            chk({cke, odt}, {cke_i, odt_i});
        end
        cmd_valid_i = 0;
        for (b = 0; b < 2; b = b + 1)
        begin
            strobe_diff_i = b[0];
            for (i = 0; i < 3; i = i + 1)
            begin
                {wr_data_i, wr_mask_i} = $urandom;
                wr_valid_i = 1;
                @(negedge clk_i);
                chk({dq_oe, sp_oe, sn_oe, dq_o, dm, sp, sn}, {2'h3, b[0], wr_data_i,
                    wr_mask_i, i[0] ? 4'h3 : 4'hc});
            end
            wr_valid_i = 0;
            @(negedge clk_i);
            chk({dq_oe, sp_oe, dm, sp}, {2'h0, 2'h3, 2'h0});
        end
        {clk_a_en_i, clk_b_en_i} = 2'h3;
        repeat (3) @(negedge clk_i);
        for (i = 0; i < 4; i = i + 1)
        begin
            b = ca_p;
            @(negedge clk_i);
            chk({ca_p, ca_n, cb_p ^ cb_n}, {~b[0], b[0], 1'b1});
        end
        {clk_a_en_i, clk_b_en_i} = 2'h0;
        repeat (2) @(negedge clk_i);
        chk({ca_p, ca_n, cb_p, cb_n}, 4'h0);
        rd_window_i = 1;
        rd_go = 1;
        for (i = 0; i < 6; i = i + 1)
        begin
            word = $urandom;
            exp_q.push_back(word);
            repeat (i == 5 ? 3 : 4) @(negedge clk_i);
        end
        rd_go = 0;
        @(negedge clk_i);
        rd_window_i = 0;
        repeat (8) @(negedge clk_i);
        chk(exp_q.size(), 0);
        conclude;
    end
endmodule // ddr2p_pins_test
